// ==== rtl/bbio_consts.svh ====
// Purpose: Constants for the bit-bang parallel IO port.
// Assumes: One channel per instance, clocked by mclk_in at 40 MHz.
// Notes:   Offsets do not exist; every control bit is a plain port.
`ifndef BBIO_CONSTS_SVH
`define BBIO_CONSTS_SVH

`define BBIO_CODE_DEFAULT 8'h00
`define BBIO_CODE_ASYNC   8'h01
`define BBIO_CODE_SYNC    8'h04
`define BBIO_BUS_W        8
`define BBIO_FIFO_DEPTH   8
`define BBIO_DIR_RESET    8'h00
`define BBIO_OUT_RESET    8'h00
`define BBIO_DIV_RESET    16'h0027
`define BBIO_DIV_W        16

`endif

// ==== rtl/bbio_pkg.sv ====
// Purpose: Types shared by the bit-bang parallel IO port.
// Assumes: Constants come from bbio_consts.svh.
// Notes:   Only types live here.
`include "bbio_consts.svh"

package bbio_pkg;

  typedef enum logic [1:0] {
    BBIO_MAIN_UART,
    BBIO_MAIN_FIFO,
    BBIO_MAIN_CPUFIFO,
    BBIO_MAIN_FASTSER
  } bbio_main_type;

  typedef enum logic [1:0] {
    BBIO_MODE_OFF,
    BBIO_MODE_ASYNC,
    BBIO_MODE_SYNC
  } bbio_mode_type;

  typedef struct packed {
    logic [`BBIO_BUS_W-1:0] data;
    logic [`BBIO_BUS_W-1:0] oe;
  } bbio_pins_type;

  typedef struct packed {
    logic wr_n;
    logic rd_n;
  } bbio_strobe_type;

endpackage : bbio_pkg

// ==== rtl/bbio_port.sv ====
// Purpose: Bit-bang parallel IO port with async and sync modes.
// Assumes: Host bytes arrive as a valid/ready stream on the same clock.
// Notes:   Samples return through an eight word FIFO that the host drains.
`timescale 1ns/100ps
`default_nettype none
`include "bbio_consts.svh"

// ****************************************
// Sample FIFO
// ****************************************
module bbio_fifo #(
  parameter int WIDTH = `BBIO_BUS_W,
  parameter int DEPTH = `BBIO_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign count_next    = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_reg <= pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
      count_reg  <= count_next;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end
endmodule : bbio_fifo

// ****************************************
// Bit-bang port top
// ****************************************
module bbio_port (
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  // Configuration
  input  wire bbio_pkg::bbio_main_type main_mode_in,
  input  wire logic                   channel_is_b_in,
  input  wire logic [`BBIO_BUS_W-1:0] dir_mask_in,
  input  wire logic [`BBIO_DIV_W-1:0] baud_div_in,
  // Mode command
  input  wire logic                   mode_cmd_valid_in,
  input  wire logic [7:0]             mode_cmd_in,
  // Host byte stream
  input  wire logic                   tx_valid_in,
  output logic                        tx_ready_out,
  input  wire logic [`BBIO_BUS_W-1:0] tx_data_in,
  // Returned samples
  output logic                        rx_valid_out,
  input  wire logic                   rx_ready_in,
  output logic      [`BBIO_BUS_W-1:0] rx_data_out,
  // Bus pins
  input  wire logic [`BBIO_BUS_W-1:0] bus_in,
  output bbio_pkg::bbio_pins_type     bus_out,
  // Strobe pins and current mode
  output bbio_pkg::bbio_strobe_type   strobe_pri_out,
  output bbio_pkg::bbio_strobe_type   strobe_alt_out,
  output bbio_pkg::bbio_mode_type     mode_out
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_RD_OFF,
    ST_UPDATE,
    ST_SETUP,
    ST_WR_ON,
    ST_WR_OFF
  } bbio_state_type;

  bbio_pkg::bbio_mode_type   mode_reg;
  bbio_pkg::bbio_mode_type   mode_next;
  bbio_state_type            state_reg;
  bbio_state_type            state_next;
  bbio_pkg::bbio_strobe_type strobe_reg;
  bbio_pkg::bbio_strobe_type strobe_next;
  logic [`BBIO_BUS_W-1:0]    out_reg;
  logic [`BBIO_BUS_W-1:0]    out_next;
  logic [`BBIO_BUS_W-1:0]    hold_reg;
  logic                      pend_reg;
  logic                      pend_next;
  logic                      ready_reg;
  logic [`BBIO_DIV_W-1:0]    baud_cnt_reg;
  logic [`BBIO_BUS_W-1:0]    sync1_reg;
  logic [`BBIO_BUS_W-1:0]    sync2_reg;
  logic [`BBIO_BUS_W-1:0]    sync3_reg;
  logic [`BBIO_BUS_W-1:0]    pins_reg;
  logic                      tx_take;
  logic                      baud_tick;
  logic                      bb_refused;
  logic                      cmd_ok;
  logic                      fifo_room;
  logic                      sample_push;
  logic                      start;

  // ****************************************
  // Pin input filter and baud tick
  // ****************************************
  // A pin change is believed once the second and third stages agree.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pins_reg  <= '0;
    end else begin
      sync1_reg <= bus_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pins_reg  <= (sync2_reg == sync3_reg) ? sync3_reg : pins_reg;
    end
  end

  assign baud_tick = (baud_cnt_reg >= baud_div_in);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      baud_cnt_reg <= '0;
    end else begin
      baud_cnt_reg <= baud_tick ? '0 : `BBIO_DIV_W'(baud_cnt_reg + 1'b1);
    end
  end

  // ****************************************
  // Mode selection
  // ****************************************
  assign bb_refused = channel_is_b_in &&
                      (main_mode_in == bbio_pkg::BBIO_MAIN_FASTSER);
  assign cmd_ok     = mode_cmd_valid_in && (state_reg == ST_IDLE);

  always_comb begin
    mode_next = mode_reg;
    if (bb_refused) begin
      mode_next = bbio_pkg::BBIO_MODE_OFF;
    end else if (cmd_ok) begin
      unique case (mode_cmd_in)
        `BBIO_CODE_DEFAULT: mode_next = bbio_pkg::BBIO_MODE_OFF;
        `BBIO_CODE_ASYNC:   mode_next = bbio_pkg::BBIO_MODE_ASYNC;
        `BBIO_CODE_SYNC:    mode_next = bbio_pkg::BBIO_MODE_SYNC;
        default:            mode_next = mode_reg;
      endcase
    end
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  // One byte is held at a time; the sequencer releases it once it is copied to the pins, before the write strobe.
  assign tx_take     = tx_valid_in && ready_reg;
  assign start       = pend_reg && (state_reg == ST_IDLE) &&
                       (mode_reg == mode_next);
  assign sample_push = (state_reg == ST_SAMPLE);

  always_comb begin
    state_next  = state_reg;
    out_next    = out_reg;
    pend_next   = pend_reg | tx_take;
    strobe_next = strobe_reg;
    unique case (state_reg)
      ST_IDLE: begin
        strobe_next.wr_n = 1'b1;
        strobe_next.rd_n = (mode_reg != bbio_pkg::BBIO_MODE_SYNC);
        if (start && mode_reg == bbio_pkg::BBIO_MODE_ASYNC && baud_tick) begin
          out_next   = hold_reg;
          pend_next  = 1'b0;
          state_next = ST_SETUP;
        end else if (start && mode_reg == bbio_pkg::BBIO_MODE_SYNC && fifo_room) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        state_next = ST_RD_OFF;
      end
      ST_RD_OFF: begin
        strobe_next.rd_n = 1'b1;
        state_next       = ST_UPDATE;
      end
      ST_UPDATE: begin
        strobe_next.rd_n = 1'b0;
        out_next         = hold_reg;
        pend_next        = 1'b0;
        state_next       = ST_SETUP;
      end
      ST_SETUP: begin
        state_next = ST_WR_ON;
      end
      ST_WR_ON: begin
        strobe_next.wr_n = 1'b0;
        state_next       = ST_WR_OFF;
      end
      ST_WR_OFF: begin
        strobe_next.wr_n = 1'b1;
        state_next       = ST_IDLE;
      end
    endcase
    if (mode_reg == bbio_pkg::BBIO_MODE_OFF) begin
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg   <= bbio_pkg::BBIO_MODE_OFF;
      state_reg  <= ST_IDLE;
      out_reg    <= `BBIO_OUT_RESET;
      hold_reg   <= `BBIO_OUT_RESET;
      pend_reg   <= 1'b0;
      ready_reg  <= 1'b0;
      strobe_reg <= '{wr_n: 1'b1, rd_n: 1'b1};
    end else begin
      mode_reg   <= mode_next;
      state_reg  <= state_next;
      out_reg    <= out_next;
      hold_reg   <= tx_take ? tx_data_in : hold_reg;
      pend_reg   <= pend_next;
      ready_reg  <= !pend_next && (mode_next != bbio_pkg::BBIO_MODE_OFF);
      strobe_reg <= strobe_next;
    end
  end

  // ****************************************
  // Sample buffer
  // ****************************************
  // Returned samples stall the sequencer when the host stops draining them.
  bbio_fifo #(
    .WIDTH (`BBIO_BUS_W),
    .DEPTH (`BBIO_FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (sample_push),
    .in_ready_out  (fifo_room),
    .in_data_in    (pins_reg),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  (rx_data_out)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign tx_ready_out = ready_reg;
  assign mode_out     = mode_reg;
  assign bus_out.data = out_reg;
  assign bus_out.oe   = (mode_reg == bbio_pkg::BBIO_MODE_OFF) ? '0 : dir_mask_in;
  assign strobe_pri_out = (main_mode_in != bbio_pkg::BBIO_MAIN_UART) ?
                          strobe_reg : bbio_pkg::bbio_strobe_type'(2'h3);
  assign strobe_alt_out = (main_mode_in == bbio_pkg::BBIO_MAIN_UART) ?
                          strobe_reg : bbio_pkg::bbio_strobe_type'(2'h3);

endmodule : bbio_port
`default_nettype wire

// ==== verif/bbio_port_sva.sv ====
// Purpose: Assertions on the bit-bang port pins.
// Assumes: Sees only top-level ports.
// Notes:   Bound at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
// ****
// Checker
// ****
module bbio_port_sva (
  input wire logic                      mclk_in,
  input wire logic                      rst_n_in,
  input wire bbio_pkg::bbio_main_type   main_mode_in,
  input wire logic                      channel_is_b_in,
  input wire logic [7:0]                dir_mask_in,
  input wire logic                      mode_cmd_valid_in,
  input wire logic [7:0]                mode_cmd_in,
  input wire logic                      tx_valid_in,
  input wire logic                      tx_ready_out,
  input wire logic [7:0]                tx_data_in,
  input wire bbio_pkg::bbio_pins_type   bus_out,
  input wire bbio_pkg::bbio_strobe_type strobe_pri_out,
  input wire bbio_pkg::bbio_strobe_type strobe_alt_out,
  input wire bbio_pkg::bbio_mode_type   mode_out
);
  wire uart    = main_mode_in == bbio_pkg::BBIO_MAIN_UART;
  wire fast_b  = channel_is_b_in && main_mode_in == bbio_pkg::BBIO_MAIN_FASTSER;
  wire is_off  = mode_out == bbio_pkg::BBIO_MODE_OFF;
  wire is_sync = mode_out == bbio_pkg::BBIO_MODE_SYNC;
  bbio_pkg::bbio_strobe_type act;
  logic [7:0]                held_reg;
  assign act = uart ? strobe_alt_out : strobe_pri_out;
  // The last byte handed over is the only value the pins may move to.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) held_reg <= 8'h00;
    else if (tx_valid_in && tx_ready_out) held_reg <= tx_data_in;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  chk_oe_follow: assert property (
    bus_out.oe == (is_off ? 8'h00 : dir_mask_in)) else $error("Pin direction wrong.");
  chk_pri_rest: assert property (
    uart && $stable(main_mode_in) |-> strobe_pri_out == 2'b11) else $error("Primary busy.");
  chk_alt_rest: assert property (
    !uart && $stable(main_mode_in) |-> strobe_alt_out == 2'b11) else $error("Alternate busy.");
  chk_fast_b_off: assert property (
    fast_b |=> is_off) else $error("Bit-bang beside fast serial.");
  chk_mode_entry: assert property (
    $changed(mode_out) && !is_off |-> $past(mode_cmd_valid_in)
      && $past(mode_cmd_in) == (is_sync ? 8'h04 : 8'h01)) else $error("Mode entered wrongly.");
  chk_mode_exit: assert property (
    $changed(mode_out) && is_off |-> $past(fast_b)
      || ($past(mode_cmd_valid_in) && $past(mode_cmd_in) == 8'h00)) else $error("Mode left wrongly.");
  chk_pins_held: assert property (
    $changed(bus_out.data) && !is_off |-> !$past(tx_ready_out) && bus_out.data == held_reg)
    else $error("Pins moved without a byte.");
  chk_wr_setup: assert property (
    $changed(bus_out.data) && !is_off |-> ##2 $fell(act.wr_n) ##1 $rose(act.wr_n))
    else $error("Write strobe misplaced.");
  chk_sync_steps: assert property (
    is_sync && $rose(act.rd_n) |=> $fell(act.rd_n) ##2 $fell(act.wr_n))
    else $error("Sync steps out of order.");
endmodule : bbio_port_sva
bind bbio_port bbio_port_sva bbio_port_sva_i (.*);
`default_nettype wire

// ==== verif/bbio_ext_model.sv ====
// Purpose: External logic clocked by the port's write strobe.
// Assumes: Drives every pin the port leaves as input.
// Notes:   Its drive moves after each write so samples show fresh data.
`timescale 1ns/100ps
`default_nettype none
// ****
// Strobe-clocked partner
// ****
module bbio_ext_model (
  // Reset
  input  wire logic       rst_n_in,
  // Strobe and pins
  input  wire logic       wr_n_in,
  output logic      [7:0] drive_out,
  output logic      [7:0] wr_count_out
);
  // Changing only at the strobe's end keeps the pins still around the write.
  always_ff @(posedge wr_n_in or negedge rst_n_in) begin
    if (!rst_n_in) wr_count_out <= 8'h00;
    else wr_count_out <= wr_count_out + 8'h01;
  end
  assign drive_out = 8'hA5 ^ wr_count_out;
endmodule : bbio_ext_model
`default_nettype wire

// ==== verif/bbio_port_tb_top.sv ====
// Purpose: Self-checking bench for the bit-bang port.
// Assumes: Strobe-clocked partner logic drives every input pin.
// Notes:   Divisor 40 keeps the async byte rate under one megabaud; sync mode is not paced by it.
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench top
// ****
module bbio_port_tb_top;
  logic                      mclk_in, rst_n_in, channel_is_b_in, mode_cmd_valid_in;
  logic                      tx_valid_in, tx_ready_out, rx_valid_out, rx_ready_in;
  logic [7:0]                dir_mask_in, mode_cmd_in, tx_data_in, rx_data_out, bus_in;
  logic [7:0]                ext_drive, wr_count, last_out, nwr, p;
  logic [15:0]               baud_div_in;
  bbio_pkg::bbio_main_type   main_mode_in;
  bbio_pkg::bbio_pins_type   bus_out;
  bbio_pkg::bbio_strobe_type strobe_pri_out, strobe_alt_out;
  bbio_pkg::bbio_mode_type   mode_out;
  int                        n_errors, n_compared;
  logic [7:0]                exp_q[$];
  wire                       wr_sel = (main_mode_in == bbio_pkg::BBIO_MAIN_UART) ?
                                      strobe_alt_out.wr_n : strobe_pri_out.wr_n;
  assign bus_in = (bus_out.data & bus_out.oe) | (ext_drive & ~bus_out.oe);
  bbio_port bbio_port_i (.*);
  bbio_ext_model bbio_ext_model_i (.rst_n_in(rst_n_in), .wr_n_in(wr_sel),
    .drive_out(ext_drive), .wr_count_out(wr_count));
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask : tick
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte
  task automatic set_mode(input logic [7:0] c, input bbio_pkg::bbio_mode_type e);
    mode_cmd_valid_in = 1'b1;
    mode_cmd_in = c;
    tick(1);
    mode_cmd_valid_in = 1'b0;
    tick(2);
    chk_byte("mode", {6'h00, e}, {6'h00, mode_out});
  endtask : set_mode
  // The bench model: a sample is the pin level just before its own byte.
  task automatic send(input logic [7:0] b);
    tx_valid_in = 1'b1;
    tx_data_in = b;
    for (int i = 0; i < 900 && tx_ready_out !== 1'b1; i++) tick(1);
    if (tx_ready_out !== 1'b1) n_errors++;
    tick(1);
    tx_valid_in = 1'b0;
    if (mode_out == bbio_pkg::BBIO_MODE_SYNC)
      exp_q.push_back((last_out & dir_mask_in) | ((8'hA5 ^ nwr) & ~dir_mask_in));
    last_out = b;
    nwr++;
    tick(10);
  endtask : send
  task automatic recv;
    for (int i = 0; i < 200 && rx_valid_out !== 1'b1; i++) tick(1);
    if (rx_valid_out !== 1'b1) n_errors++;
    chk_byte("sample", exp_q.pop_front(), rx_data_out);
    rx_ready_in = 1'b1;
    tick(1);
    rx_ready_in = 1'b0;
    tick(1);
  endtask : recv
  task automatic complete_run;
    $display("Errors %0d, compares %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end
  initial begin
    {rst_n_in, channel_is_b_in, mode_cmd_valid_in, tx_valid_in, rx_ready_in} = 5'h00;
    {mode_cmd_in, tx_data_in, last_out, nwr} = 32'h0000_0000;
    main_mode_in = bbio_pkg::BBIO_MAIN_FIFO;
    baud_div_in = 16'h0028;
    void'($urandom(32'h3526));
    dir_mask_in = 8'($urandom);
    tick(5);
    chk_byte("reset", 8'hF0, {strobe_pri_out, strobe_alt_out, tx_ready_out, rx_valid_out, 2'h0});
    rst_n_in = 1'b1;
    tick(1);
    set_mode(8'h01, bbio_pkg::BBIO_MODE_ASYNC);
    set_mode(8'h02, bbio_pkg::BBIO_MODE_ASYNC);
    set_mode(8'h04, bbio_pkg::BBIO_MODE_SYNC);
    set_mode(8'h00, bbio_pkg::BBIO_MODE_OFF);
    channel_is_b_in = 1'b1;
    main_mode_in = bbio_pkg::BBIO_MAIN_FASTSER;
    set_mode(8'h01, bbio_pkg::BBIO_MODE_OFF);
    channel_is_b_in = 1'b0;
    set_mode(8'h01, bbio_pkg::BBIO_MODE_ASYNC);
    for (int m = 0; m < 4; m++) begin
      main_mode_in = bbio_pkg::bbio_main_type'(m[1:0]);
      send(8'($urandom));
      for (int i = 0; i < 400 && tx_ready_out !== 1'b1; i++) tick(1);
      if (tx_ready_out !== 1'b1) n_errors++;
      tick(4);
      chk_byte("pins", last_out, bus_out.data);
      chk_byte("writes", nwr, wr_count);
    end
    tick(200);
    chk_byte("hold", last_out, bus_out.data);
    main_mode_in = bbio_pkg::BBIO_MAIN_FIFO;
    set_mode(8'h04, bbio_pkg::BBIO_MODE_SYNC);
    repeat (8) send(8'($urandom));
    p = last_out;
    send(8'($urandom));
    tick(60);
    chk_byte("stall pins", p, bus_out.data);
    chk_byte("stall ready", 8'h00, {7'h00, tx_ready_out});
    repeat (8) recv();
    send(last_out);
    repeat (2) recv();
    tick(20);
    chk_byte("left", 8'h00, {7'h00, rx_valid_out});
    complete_run();
  end
endmodule : bbio_port_tb_top
`default_nettype wire
